// [core/uos_consts.svh]
// Register offsets, field positions, reset values and timing counts of the USB status block.
// Assumes a 25 MHz register clock and a bit-time strobe supplied by the link logic.
`ifndef UOS_CONSTS_SVH
`define UOS_CONSTS_SVH

`define UOS_OFS_LINE_STATUS   8'h00
`define UOS_OFS_ERROR_FLAGS   8'h04
`define UOS_OFS_ERROR_MASK    8'h08
`define UOS_OFS_CONTROL       8'h0C

`define UOS_BIT_CABLE_ID      7
`define UOS_BIT_LINE_STABLE   5
`define UOS_BIT_SESSION_VALID 3
`define UOS_BIT_B_SESS_END    2
`define UOS_BIT_A_SUPPLY_VAL  0

`define UOS_BIT_STUFF_ERR     7
`define UOS_BIT_BUS_MATRIX    6
`define UOS_BIT_DMA_ERR       5
`define UOS_BIT_TURNAROUND    4
`define UOS_BIT_BYTE_LEN      3
`define UOS_BIT_DATA_CRC      2
`define UOS_BIT_TOKEN_EOF     1
`define UOS_BIT_PACKET_ID     0

`define UOS_BIT_HOST_MODE     0

`define UOS_RST_FLAGS         8'h00
`define UOS_RST_MASK          8'h00

`define UOS_CLK_HZ            25000000
`define UOS_STABLE_US         1000
`define UOS_STABLE_CYC        ((`UOS_CLK_HZ / 1000000) * `UOS_STABLE_US)
`define UOS_TURNAROUND_BITS   16

`endif

// [core/uos_pkg.sv]
// Types shared by the USB status and error-flag block.
// Assumes the constants header is included by the modules that need offsets.
package uos_pkg;

   typedef struct packed {
      logic stuff_err;
      logic bus_matrix_err;
      logic dma_err;
      logic turnaround_err;
      logic byte_len_err;
      logic data_crc_err;
      logic token_crc_err;
      logic packet_id_err;
   } uos_err_evt_t;

   typedef struct packed {
      logic cable_identity;
      logic single_ended_zero_state;
      logic j_line_state;
      logic session_valid;
      logic b_session_end;
      logic a_supply_valid;
   } uos_line_in_t;

   typedef enum logic [1:0] {
      UOS_TA_IDLE  = 2'b00,
      UOS_TA_WAIT  = 2'b01,
      UOS_TA_FIRED = 2'b11
   } uos_ta_state_t;

endpackage

// [core/uos_sync2.sv]
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to ref_clk_i.
`timescale 1ns/1ps
module uos_sync2 (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   // Level
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// [core/uos_w1c_flag.sv]
// One hardware-set, write-one-to-clear flag.
// Assumes set and clear are single-cycle terms on ref_clk_i.
`timescale 1ns/1ps
module uos_w1c_flag (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   // Set and clear
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         // A set in the clearing cycle must not be lost.
         flag_o <= 1'b1; // RULE16
      end else if (clr_i) begin
         flag_o <= 1'b0; // RULE7
      end
   end
endmodule

// [core/uos_status_top.sv]
// Function
// RULE1 - Status bit 7 shows cable identity: 1 none or B cable, 0 A cable.
// RULE2 - Status bit 5 set only when SE0 and J unchanged for the last 1 ms.
// RULE3 - Status bit 3 shows supply above session-valid threshold, either side.
// RULE4 - Status bit 2 shows B-side supply below session-valid threshold.
// RULE5 - Status bit 0 shows A-side supply above session-valid threshold.
// RULE6 - Unused and upper status bits read zero and ignore writes.
// RULE7 - Error flags set by hardware, reset zero, cleared by writing one.
// RULE8 - Bit-stuff violation rejects the packet and sets flag bit 7.
// RULE9 - Invalid descriptor table or buffer address sets flag bit 6.
// RULE10 - Late memory grant or truncated packet sets DMA flag bit 5.
// RULE11 - Over 16 idle bit-times after end-of-packet without reply sets bit 4.
// RULE12 - Data field not a whole number of bytes sets flag bit 3.
// RULE13 - Data packet with failed CRC16 is rejected and sets bit 2.
// RULE14 - Bit 1 is token CRC5 error as device, end-of-frame error as host.
// RULE15 - Packet identifier failing its complement check sets flag bit 0.
// RULE16 - Hardware set and software clear in one cycle leaves flag set.
//
// Holds the AXI4-Lite register slave, line-state filter, turnaround timer and flags.
// Assumes pins arrive asynchronously and packet events are one-cycle pulses on ref_clk_i.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "uos_consts.svh"
module uos_status_top
   import uos_pkg::*;
(
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         reset_i,
   // AXI4-Lite write address
   input  wire logic         s_axi_awvalid_i,
   output logic              s_axi_awready_o,
   input  wire logic [7:0]   s_axi_awaddr_i,
   // AXI4-Lite write data
   input  wire logic         s_axi_wvalid_i,
   output logic              s_axi_wready_o,
   input  wire logic [31:0]  s_axi_wdata_i,
   input  wire logic [3:0]   s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic              s_axi_bvalid_o,
   input  wire logic         s_axi_bready_i,
   output logic [1:0]        s_axi_bresp_o,
   // AXI4-Lite read address
   input  wire logic         s_axi_arvalid_i,
   output logic              s_axi_arready_o,
   input  wire logic [7:0]   s_axi_araddr_i,
   // AXI4-Lite read data
   output logic              s_axi_rvalid_o,
   input  wire logic         s_axi_rready_i,
   output logic [31:0]       s_axi_rdata_o,
   output logic [1:0]        s_axi_rresp_o,
   // Cable pins and comparators, asynchronous
   input  wire uos_line_in_t line_pins_i,
   // Packet engine events, one-cycle pulses
   input  wire uos_err_evt_t err_evt_i,
   input  wire logic         eof_active_sof_zero_i,
   input  wire logic         bit_time_i,
   input  wire logic         eop_seen_i,
   input  wire logic         response_seen_i,
   input  wire logic         response_expected_i,
   // Packet verdict
   input  wire logic         pkt_end_i,
   output logic              pkt_reject_o,
   // Interrupt
   output logic              irq_o
);

   localparam int STABLE_CYC = `UOS_STABLE_CYC;

   // Synchronised pins.
   logic [5:0] pin_sync;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_sync
         uos_sync2 u_sync (
            .ref_clk_i (ref_clk_i),
            .reset_i   (reset_i),
            .async_i   (line_pins_i[gi]),
            .sync_o    (pin_sync[gi])
         );
      end
   endgenerate

   logic cable_id_s;
   logic se0_s;
   logic jst_s;
   logic sess_s;
   logic bend_s;
   logic avld_s;
   assign {cable_id_s, se0_s, jst_s, sess_s, bend_s, avld_s} = pin_sync;

   // Line-state stability filter on the synchronised levels.
   // A pin change restarts the 1 ms count about three clocks later.
   logic [1:0]  line_prev_q;
   logic [15:0] stable_cnt_q;
   logic        line_stable_q;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         line_prev_q   <= 2'h0;
         stable_cnt_q  <= 16'h0000;
         line_stable_q <= 1'b0;
      end else begin
         line_prev_q <= {se0_s, jst_s};
         if ({se0_s, jst_s} != line_prev_q) begin
            stable_cnt_q  <= 16'h0000; // RULE2
            line_stable_q <= 1'b0;
         end else if (stable_cnt_q < 16'(STABLE_CYC - 1)) begin
            stable_cnt_q  <= stable_cnt_q + 16'h0001;
            line_stable_q <= 1'b0;
         end else begin
            line_stable_q <= 1'b1; // RULE2
         end
      end
   end

   // Status register image, refreshed every clock.
   // Every read field comes from a flop, all refreshed on one edge.
   logic [7:0] line_status_q;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         line_status_q <= 8'h00;
      end else begin
         line_status_q                         <= 8'h00; // RULE6
         line_status_q[`UOS_BIT_CABLE_ID]      <= cable_id_s; // RULE1
         line_status_q[`UOS_BIT_LINE_STABLE]   <= line_stable_q; // RULE2
         line_status_q[`UOS_BIT_SESSION_VALID] <= sess_s; // RULE3
         line_status_q[`UOS_BIT_B_SESS_END]    <= bend_s; // RULE4
         line_status_q[`UOS_BIT_A_SUPPLY_VAL]  <= avld_s; // RULE5
      end
   end

   // Turnaround timer counts bit-times from end-of-packet until the reply.
   // A reply on the deadline pulse still counts as in time.
   // Packet ends during a wait do not restart it; one timeout per packet.
   uos_ta_state_t ta_state_q;
   logic [4:0]    ta_cnt_q;
   logic          ta_timeout;

   assign ta_timeout = (ta_state_q == UOS_TA_WAIT) && bit_time_i && !response_seen_i
                       && (ta_cnt_q == 5'(`UOS_TURNAROUND_BITS));

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ta_state_q <= UOS_TA_IDLE;
         ta_cnt_q   <= 5'h00;
      end else begin
         unique case (ta_state_q)
            UOS_TA_IDLE: begin
               if (eop_seen_i && response_expected_i) begin
                  ta_state_q <= UOS_TA_WAIT;
                  ta_cnt_q   <= 5'h00;
               end
            end
            UOS_TA_WAIT: begin
               if (response_seen_i) begin
                  ta_state_q <= UOS_TA_IDLE;
               end else if (ta_timeout) begin
                  ta_state_q <= UOS_TA_FIRED; // RULE11
               end else if (bit_time_i) begin
                  ta_cnt_q <= ta_cnt_q + 5'h01;
               end
            end
            UOS_TA_FIRED: begin
               ta_state_q <= UOS_TA_IDLE;
            end
            default: begin
               ta_state_q <= UOS_TA_IDLE;
            end
         endcase
      end
   end

   // Control: host mode picks the meaning of flag bit 1.
   // A mode change leaves flags already set untouched.
   logic [7:0] control_q;
   logic [7:0] mask_q;
   logic       host_mode;
   assign host_mode = control_q[`UOS_BIT_HOST_MODE];

   // Hardware set terms for each flag.
   logic [7:0] flag_set;
   always_comb begin
      flag_set                        = 8'h00;
      flag_set[`UOS_BIT_STUFF_ERR]    = err_evt_i.stuff_err; // RULE8
      flag_set[`UOS_BIT_BUS_MATRIX]   = err_evt_i.bus_matrix_err; // RULE9
      flag_set[`UOS_BIT_DMA_ERR]      = err_evt_i.dma_err; // RULE10
      flag_set[`UOS_BIT_TURNAROUND]   = err_evt_i.turnaround_err | ta_timeout; // RULE11
      flag_set[`UOS_BIT_BYTE_LEN]     = err_evt_i.byte_len_err; // RULE12
      flag_set[`UOS_BIT_DATA_CRC]     = err_evt_i.data_crc_err; // RULE13
      flag_set[`UOS_BIT_TOKEN_EOF]    = host_mode ? eof_active_sof_zero_i
                                                  : err_evt_i.token_crc_err; // RULE14
      flag_set[`UOS_BIT_PACKET_ID]    = err_evt_i.packet_id_err; // RULE15
   end

   // Packet rejection verdict: stuff, CRC16 and PID errors discard the packet.
   // Faults are remembered until the end, so early faults still reject.
   // A fault in the end cycle itself counts for the packet that ends.
   logic rej_pend_q;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rej_pend_q   <= 1'b0;
         pkt_reject_o <= 1'b0;
      end else begin
         pkt_reject_o <= pkt_end_i && (rej_pend_q || err_evt_i.stuff_err
                         || err_evt_i.data_crc_err || err_evt_i.packet_id_err); // RULE8
         if (pkt_end_i) begin
            rej_pend_q <= 1'b0;
         end else if (err_evt_i.stuff_err || err_evt_i.data_crc_err
                      || err_evt_i.packet_id_err) begin
            rej_pend_q <= 1'b1; // RULE13
         end
      end
   end

   // AXI4-Lite write path: address and data are latched independently.
   // Only byte lane 0 holds register bits; upper lanes are dropped.
   // The response waits for both halves, offered in either order.
   logic       aw_hold_q;
   logic       w_hold_q;
   logic [7:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic       w_lane0_q;
   logic       wr_fire;

   assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid_o;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         aw_hold_q       <= 1'b0;
         w_hold_q        <= 1'b0;
         aw_addr_q       <= 8'h00;
         w_data_q        <= 8'h00;
         w_lane0_q       <= 1'b0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= 2'h0;
      end else begin
         s_axi_awready_o <= !aw_hold_q && !(s_axi_awvalid_i && s_axi_awready_o);
         s_axi_wready_o  <= !w_hold_q && !(s_axi_wvalid_i && s_axi_wready_o);
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_q  <= 1'b1;
            w_data_q  <= s_axi_wdata_i[7:0];
            w_lane0_q <= s_axi_wstrb_i[0];
         end
         if (wr_fire) begin
            aw_hold_q      <= 1'b0;
            w_hold_q       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            unique case (aw_addr_q)
               `UOS_OFS_LINE_STATUS,
               `UOS_OFS_ERROR_FLAGS,
               `UOS_OFS_ERROR_MASK,
               `UOS_OFS_CONTROL: s_axi_bresp_o <= 2'h0;
               default:          s_axi_bresp_o <= 2'h2;
            endcase
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   logic wr_lo;
   assign wr_lo = wr_fire && w_lane0_q;

   // Writable registers: mask and control.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         mask_q    <= `UOS_RST_MASK;
         control_q <= 8'h00;
      end else if (wr_lo && aw_addr_q == `UOS_OFS_ERROR_MASK) begin
         mask_q <= w_data_q;
      end else if (wr_lo && aw_addr_q == `UOS_OFS_CONTROL) begin
         control_q <= {7'h00, w_data_q[`UOS_BIT_HOST_MODE]};
      end
   end

   // Error flags.
   // A clear is one pulse per completed write; zero bits leave flags alone.
   // A fault arriving with the clear wins, so no event is lost.
   logic [7:0] flag_clr;
   logic [7:0] err_flags;
   assign flag_clr = (wr_lo && aw_addr_q == `UOS_OFS_ERROR_FLAGS) ? w_data_q : 8'h00;

   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         uos_w1c_flag u_flag (
            .ref_clk_i (ref_clk_i),
            .reset_i   (reset_i),
            .set_i     (flag_set[gi]),
            .clr_i     (flag_clr[gi]),
            .flag_o    (err_flags[gi])
         );
      end
   endgenerate

   // Registered, so the interrupt trails a flag change by one clock.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(err_flags & mask_q);
      end
   end

   // AXI4-Lite read path, one read at a time.
   // Data is captured as the address is taken, so a read never tears.
   // A flag set in that same cycle appears on the next read.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= 2'h0;
      end else begin
         s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= 2'h0;
            unique case (s_axi_araddr_i)
               `UOS_OFS_LINE_STATUS: s_axi_rdata_o <= {24'h000000, line_status_q}; // RULE6
               `UOS_OFS_ERROR_FLAGS: s_axi_rdata_o <= {24'h000000, err_flags};
               `UOS_OFS_ERROR_MASK:  s_axi_rdata_o <= {24'h000000, mask_q};
               `UOS_OFS_CONTROL:     s_axi_rdata_o <= {24'h000000, control_q};
               default: begin
                  s_axi_rdata_o <= 32'h0000_0000;
                  s_axi_rresp_o <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

endmodule

// [tb/uos_status_sva.sv]
// Checker of the USB status block: bus answers, packet verdict, line filter.
// Assumes it is bound to uos_status_top and sees only its ports.
`timescale 1ns/1ps
`include "uos_consts.svh"
module uos_status_sva
   import uos_pkg::*;
(
   // Clock and reset
   input wire logic         ref_clk_i,
   input wire logic         reset_i,
   // Register bus
   input wire logic         s_axi_arvalid_i,
   input wire logic         s_axi_arready_o,
   input wire logic [7:0]   s_axi_araddr_i,
   input wire logic         s_axi_rvalid_o,
   input wire logic [31:0]  s_axi_rdata_o,
   input wire logic [1:0]   s_axi_rresp_o,
   input wire logic         s_axi_bvalid_o,
   input wire logic         s_axi_bready_i,
   input wire logic [1:0]   s_axi_bresp_o,
   // Link side
   input wire uos_line_in_t line_pins_i,
   input wire uos_err_evt_t err_evt_i,
   input wire logic         pkt_end_i,
   input wire logic         pkt_reject_o
);
   logic [7:0]  ra_q;
   logic [1:0]  line_q;
   logic [14:0] calm_q;
   logic [1:0]  line_now;

   assign line_now = {line_pins_i.single_ended_zero_state, line_pins_i.j_line_state};

   always_ff @(posedge ref_clk_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) ra_q <= s_axi_araddr_i;
   end

   // Age of the raw line state; saturates so it never wraps back to small values.
   always_ff @(posedge ref_clk_i) begin
      line_q <= line_now;
      if (reset_i || line_q != line_now) calm_q <= 15'h0000;
      else if (calm_q != 15'h7FFF) calm_q <= calm_q + 15'h0001;
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   a_reject_stuff: assert property (pkt_end_i && err_evt_i.stuff_err |=> pkt_reject_o)
      else $error("packet with stuff error not rejected");
   a_reject_crc: assert property (pkt_end_i && err_evt_i.data_crc_err |=> pkt_reject_o)
      else $error("packet with data crc error not rejected");
   a_reject_pid: assert property (pkt_end_i && err_evt_i.packet_id_err |=> pkt_reject_o)
      else $error("packet with id error not rejected");
   a_reject_cause: assert property (pkt_reject_o |-> $past(pkt_end_i))
      else $error("reject without packet end");
   a_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_status_holes: assert property (s_axi_rvalid_o && ra_q == `UOS_OFS_LINE_STATUS
      |-> (s_axi_rdata_o[7:0] & 8'h52) == 8'h00)
      else $error("unused status bits not zero");
   a_stable_age: assert property (s_axi_rvalid_o && ra_q == `UOS_OFS_LINE_STATUS
      && s_axi_rdata_o[5] |-> calm_q >= 15'h61A8 || calm_q < 15'h0004)
      else $error("line stable shown too early");
   a_unmapped_err: assert property (s_axi_rvalid_o && ra_q >= 8'h10
      |-> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
      else $error("unmapped read not refused");
   a_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   a_resp_taken: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response not retired");

   c_reject: cover property (pkt_reject_o);
   c_stable: cover property (s_axi_rvalid_o && s_axi_rdata_o[5]);
   c_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
endmodule
bind uos_status_top uos_status_sva chk_u (.ref_clk_i, .reset_i, .s_axi_arvalid_i,
   .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rdata_o, .s_axi_rresp_o,
   .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .line_pins_i, .err_evt_i,
   .pkt_end_i, .pkt_reject_o);

// [tb/uos_link_model.sv]
// Far side of the cable: ends packets with chosen faults and may answer late.
// Assumes one clock; bit times run free as the link logic would make them.
`timescale 1ns/1ps
module uos_link_model
   import uos_pkg::*;
#(
   parameter int BIT_DIV = 2
)(
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         reset_i,
   // Commands from the bench
   input  wire logic         go_i,
   input  wire uos_err_evt_t err_i,
   input  wire logic         answer_i,
   input  wire logic [4:0]   wait_i,
   // Towards the block
   output uos_err_evt_t      err_evt_o,
   output logic              pkt_end_o,
   output logic              eop_o,
   output logic              bit_time_o,
   output logic              response_o
);
   logic [3:0] div_q;
   logic [5:0] left_q;

   always_ff @(posedge ref_clk_i) begin
      div_q      <= (reset_i || div_q == 4'(BIT_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      bit_time_o <= !reset_i && div_q == 4'h0;
   end

   // Faults land in the last cycle of the packet, together with its end.
   always_ff @(posedge ref_clk_i) begin
      err_evt_o <= go_i ? err_i : '0;
      pkt_end_o <= go_i;
      eop_o     <= go_i;
   end

   always_ff @(posedge ref_clk_i) begin
      response_o <= 1'h0;
      if (reset_i) left_q <= 6'h00;
      else if (go_i && answer_i) left_q <= {1'h0, wait_i} + 6'h01;
      else if (left_q != 6'h00 && bit_time_o) begin
         left_q     <= left_q - 6'h01;
         response_o <= left_q == 6'h01;
      end
   end
endmodule

// [tb/uos_status_top_tb.sv]
// Self-checking bench of the USB status block over its register bus.
// Assumes the link model makes packet events and the bench drives the pins.
`timescale 1ns/1ps
`include "uos_consts.svh"
module uos_status_top_tb;
   import uos_pkg::*;
   logic         ref_clk_i = 1'h0;
   logic         reset_i = 1'h1;
   logic         awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic         go = 1'h0, ans = 1'h0, eofz = 1'h0, rexp = 1'h0;
   logic         awr, wrd, bv, arr, rv, rej, irq, bt, eop, pend, resp;
   logic [1:0]   br, rr, rres, bres;
   logic [7:0]   awa = 8'h00, ara = 8'h00;
   logic [31:0]  wd = 32'h0, rdat, rdata;
   logic [4:0]   wt = 5'h05;
   uos_err_evt_t evt, err = '0;
   uos_line_in_t pins = 6'h22;
   int           err_total = 0, n_compared = 0;

   always #20 ref_clk_i = ~ref_clk_i;

   uos_status_top dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
      .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
      .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rr),
      .line_pins_i(pins), .err_evt_i(evt), .eof_active_sof_zero_i(eofz), .bit_time_i(bt),
      .eop_seen_i(eop), .response_seen_i(resp), .response_expected_i(rexp),
      .pkt_end_i(pend), .pkt_reject_o(rej), .irq_o(irq));

   uos_link_model #(.BIT_DIV(2)) far_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .go_i(go), .err_i(err), .answer_i(ans), .wait_i(wt), .err_evt_o(evt),
      .pkt_end_o(pend), .eop_o(eop), .bit_time_o(bt), .response_o(resp));

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s: expected %h seen %h", s, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      awa <= a;
      wd  <= d;
      awv <= 1'h1;
      wv  <= 1'h1;
      bry <= 1'h1;
      do begin
         @(posedge ref_clk_i);
         if (awr) awv <= 1'h0;
         if (wrd) wv <= 1'h0;
      end while (bv !== 1'h1);
      bres = br;
      bry <= 1'h0;
   endtask

   task automatic rk(input logic [7:0] a, input logic [31:0] e, input string s);
      @(posedge ref_clk_i);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do begin
         @(posedge ref_clk_i);
         if (arr) arv <= 1'h0;
      end while (rv !== 1'h1);
      rdat = rdata;
      rres = rr;
      rry <= 1'h0;
      chk(s, e, rdat);
   endtask

   task automatic pkt(input uos_err_evt_t e, input logic an, input logic x);
      @(posedge ref_clk_i);
      go  <= 1'h1;
      rexp <= x;
      err <= e;
      ans <= an;
      @(posedge ref_clk_i);
      go  <= 1'h0;
      repeat (3) @(posedge ref_clk_i);
   endtask

   task automatic t_reset;
      rk(`UOS_OFS_ERROR_FLAGS, 32'h0, "flags at reset");
      rk(`UOS_OFS_ERROR_MASK, 32'h0, "mask at reset");
      wr(`UOS_OFS_LINE_STATUS, 32'hFFFFFFFF);
      rk(`UOS_OFS_LINE_STATUS, 32'h84, "status after write");
      rk(8'h40, 32'h0, "unmapped data");
      chk("unmapped resp", 32'h2, {30'h0, rres});
      wr(8'h40, 32'h0);
      chk("unmapped write resp", 32'h2, {30'h0, bres});
      $display("test reset done");
   endtask

   task automatic t_pins;
      pins <= 6'h05;
      repeat (4) @(posedge ref_clk_i);
      rk(`UOS_OFS_LINE_STATUS, 32'h09, "status pins a");
      pins <= 6'h22;
      repeat (4) @(posedge ref_clk_i);
      rk(`UOS_OFS_LINE_STATUS, 32'h84, "status pins b");
      $display("test pins done");
   endtask

   task automatic t_flags;
      wr(`UOS_OFS_ERROR_MASK, 32'hFF);
      for (int i = 0; i < 8; i++) begin
         pkt(8'h01 << i, 1'h0, 1'h0);
         rk(`UOS_OFS_ERROR_FLAGS, 32'h1 << i, "flag set");
         chk("irq on", 32'h1, {31'h0, irq});
         wr(`UOS_OFS_ERROR_FLAGS, 32'h0);
         rk(`UOS_OFS_ERROR_FLAGS, 32'h1 << i, "flag after zero");
         wr(`UOS_OFS_ERROR_FLAGS, 32'h1 << i);
         rk(`UOS_OFS_ERROR_FLAGS, 32'h0, "flag cleared");
         chk("irq off", 32'h0, {31'h0, irq});
      end
      wr(`UOS_OFS_ERROR_MASK, 32'h0);
      pkt(8'h08, 1'h0, 1'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`UOS_OFS_ERROR_MASK, 32'h08);
      repeat (2) @(posedge ref_clk_i);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(`UOS_OFS_ERROR_FLAGS, 32'h08);
      $display("test flags done");
   endtask

   task automatic t_host;
      wr(`UOS_OFS_CONTROL, 32'h1);
      pkt(8'h02, 1'h0, 1'h0);
      rk(`UOS_OFS_ERROR_FLAGS, 32'h0, "token error as host");
      eofz <= 1'h1;
      @(posedge ref_clk_i);
      eofz <= 1'h0;
      rk(`UOS_OFS_ERROR_FLAGS, 32'h02, "frame end error");
      wr(`UOS_OFS_ERROR_FLAGS, 32'h02);
      wr(`UOS_OFS_CONTROL, 32'h0);
      $display("test host done");
   endtask

   task automatic t_race;
      // The write lands its clear on the very edge that samples the new fault.
      fork
         wr(`UOS_OFS_ERROR_FLAGS, 32'h01);
         pkt(8'h01, 1'h0, 1'h0);
      join
      rk(`UOS_OFS_ERROR_FLAGS, 32'h01, "set beats clear");
      wr(`UOS_OFS_ERROR_FLAGS, 32'h01);
      $display("test race done");
   endtask

   task automatic t_ta;
      pkt(8'h00, 1'h1, 1'h1);
      repeat (60) @(posedge ref_clk_i);
      rk(`UOS_OFS_ERROR_FLAGS, 32'h0, "answered in time");
      pkt(8'h00, 1'h0, 1'h1);
      repeat (26) @(posedge ref_clk_i);
      rk(`UOS_OFS_ERROR_FLAGS, 32'h0, "turnaround early");
      repeat (20) @(posedge ref_clk_i);
      rk(`UOS_OFS_ERROR_FLAGS, 32'h10, "turnaround late");
      wr(`UOS_OFS_ERROR_FLAGS, 32'h10);
      $display("test turnaround done");
   endtask

   task automatic t_stable;
      pins <= 6'h2A;
      repeat (24900) @(posedge ref_clk_i);
      rk(`UOS_OFS_LINE_STATUS, 32'h84, "line not yet stable");
      repeat (200) @(posedge ref_clk_i);
      rk(`UOS_OFS_LINE_STATUS, 32'hA4, "line stable");
      pins <= 6'h22;
      repeat (4) @(posedge ref_clk_i);
      rk(`UOS_OFS_LINE_STATUS, 32'h84, "line moved");
      $display("test stable done");
   endtask

   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'h0;
      repeat (2) @(posedge ref_clk_i);
      t_reset;
      t_pins;
      t_flags;
      t_host;
      t_race;
      t_ta;
      t_stable;
      summarize;
   end

   initial begin
      repeat (40000) @(posedge ref_clk_i);
      err_total++;
      summarize;
   end
endmodule
